// ---- rtl/sadc_cfg.svh ----
/*
  Fixed figures of the sampling converter digital side: word widths,
  code limits, sign-extension shifts of the gain stage and pipeline timing.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

`define SADC_RES_W 12
`define SADC_AIN_W 16
`define SADC_CODE_MIN 12'h800
`define SADC_CODE_MAX 12'h7ff
`define SADC_CODE_ZERO 12'h000
`define SADC_CODE_NEG1 12'hfff
`define SADC_SAT_HI 16'sh07ff
`define SADC_SAT_LO 16'shf800
`define SADC_SHIFT_UNITY 4
`define SADC_SHIFT_DOUBLE 3
`define SADC_DBL_LIM 16'sh3fff
`define SADC_DBL_LIM_N 16'shc000
`define SADC_CLK_NS 100
`define SADC_CONV_NS 70
`define SADC_CONV_CYC \
  (((`SADC_CONV_NS / `SADC_CLK_NS) < 1) ? 1 : (`SADC_CONV_NS / `SADC_CLK_NS))
`define SADC_PIPE_CYC 2
`define SADC_LAT_EDGES 3
`define SADC_FILL_CNT 2'h3
`define SADC_AIN_ZERO 16'sh0000
`define SADC_AIN_NEG1 16'shffff
`define SADC_AIN_POS_FS 16'sh7fff
`define SADC_AIN_NEG_FS 16'sh8000

`endif

// ---- rtl/sadc_pkg.sv ----
/*
  Types and the quantiser function shared by the converter modules.
  Assumes sadc_cfg.svh is reachable on the include path.
*/
`include "sadc_cfg.svh"

package sadc_pkg;

  typedef logic signed [`SADC_AIN_W-1:0] sadc_ain_t;
  typedef logic [`SADC_RES_W-1:0] sadc_code_t;

  typedef enum logic {
    SADC_GAIN_DOUBLE = 1'b0,
    SADC_GAIN_UNITY = 1'b1
  } sadc_gain_e;

  // floor division keeps the zero crossing between 000 and fff
  function automatic sadc_code_t sadc_quantize(input sadc_ain_t ain,
                                               input sadc_gain_e gain);
    sadc_ain_t sh;
    sadc_code_t code;
    sh = (gain == SADC_GAIN_UNITY) ? (ain >>> `SADC_SHIFT_UNITY)
                                   : (ain >>> `SADC_SHIFT_DOUBLE);
    if (sh > `SADC_SAT_HI) begin
      code = `SADC_CODE_MAX;
    end else if (sh < `SADC_SAT_LO) begin
      code = `SADC_CODE_MIN;
    end else begin
      code = sh[`SADC_RES_W-1:0];
    end
    return code;
  endfunction

  function automatic logic sadc_is_range_end(input sadc_code_t code);
    return (code == `SADC_CODE_MIN) || (code == `SADC_CODE_MAX);
  endfunction

endpackage

// ---- rtl/sadc_conv_if.sv ----
/*
  Carrier between the pipeline top and the conversion stage.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
`include "sadc_cfg.svh"

interface sadc_conv_if;
  sadc_pkg::sadc_ain_t sample;
  sadc_pkg::sadc_gain_e gain;
  logic take;
  sadc_pkg::sadc_code_t code;
  logic ovf;
  logic done;

  modport stage (input sample, input gain, input take,
                 output code, output ovf, output done);
  modport pipe (output sample, output gain, output take,
                input code, input ovf, input done);
endinterface

// ---- rtl/sadc_conv_stage.sv ----
/*
  Conversion stage: turns one held sample into a code and its range flag
  in one clock. Assumes the sample and gain stay put for that clock.
*/
`timescale 1ns/1ps
`include "sadc_cfg.svh"

module sadc_conv_stage (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sample in, code out
  sadc_conv_if.stage cv
);

  sadc_pkg::sadc_code_t code_r;
  logic ovf_r;
  logic done_r;

  // a started conversion runs to its end; only arst_n can cut it short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_r <= `SADC_CODE_ZERO;
      ovf_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      code_r <= sadc_pkg::sadc_quantize(cv.sample, cv.gain);
      ovf_r <= sadc_pkg::sadc_is_range_end(
                 sadc_pkg::sadc_quantize(cv.sample, cv.gain));
      done_r <= cv.take;
    end
  end

  assign cv.code = code_r;
  assign cv.ovf = ovf_r;
  assign cv.done = done_r;

endmodule

// ---- rtl/sadc_top.sv ----
/*
  Digital side of a 12-bit pipelined sampling converter: samples on every
  rising edge, converts, and presents the word and range flag two clocks
  later. Assumes a free-running clock; the analog input arrives as a
  signed word synchronous to clk, full span at unity gain.
*/
`timescale 1ns/1ps
`include "sadc_cfg.svh"

// How it works
// - every result leaves as a 12-bit two's complement word.
// - overflow flag is high exactly for codes 800 and 7ff.
// - zero crossing sits between codes 000 and fff.
// - a new sample is taken on every rising clock edge.
// - a started conversion is never restarted; only arst_n aborts it.
// - the word is refreshed one clock after the end of each conversion.
// - each result waits one extra pipeline clock after its one-clock conversion before output.
// - only rising clock edges time the logic; duty cycle is free.
// - gain pin high gives unity gain, low halves the input span.
module sadc_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // analog side, already digitised and synchronous
  input wire sadc_pkg::sadc_ain_t analog_in,
  input wire logic gain_sel,
  // parallel result
  output sadc_pkg::sadc_code_t result,
  output logic overflow_flag,
  output logic result_valid
);

  sadc_conv_if cv ();

  sadc_pkg::sadc_ain_t sample_r;
  sadc_pkg::sadc_gain_e gain_r;
  logic smp_v_r;
  sadc_pkg::sadc_code_t result_r;
  logic overflow_flag_r;
  logic result_valid_r;

  // sampling: the input is frozen on each rising edge, no gaps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_r <= '0;
      gain_r <= sadc_pkg::SADC_GAIN_UNITY;
      smp_v_r <= 1'b0;
    end else begin
      sample_r <= analog_in;
      gain_r <= sadc_pkg::sadc_gain_e'(gain_sel);
      smp_v_r <= 1'b1;
    end
  end

  assign cv.sample = sample_r;
  assign cv.gain = gain_r;
  assign cv.take = smp_v_r;

  sadc_conv_stage i_sadc_conv_stage (
    .clk(clk),
    .arst_n(arst_n),
    .cv(cv)
  );

  // output pipeline stage; word and flag move as one so a receiver
  // latching on any edge never sees a flag from another sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= `SADC_CODE_ZERO;
      overflow_flag_r <= 1'b0;
      result_valid_r <= 1'b0;
    end else begin
      result_r <= cv.code;
      overflow_flag_r <= cv.ovf;
      result_valid_r <= cv.done;
    end
  end

  // offset binary is the receiver's job: it flips result[11] only
  assign result = result_r;
  assign overflow_flag = overflow_flag_r;
  assign result_valid = result_valid_r;

  // checks

  a_sample_each_edge: assert property (
    @(posedge clk) disable iff (!arst_n)
    $past(arst_n) |-> (sample_r == $past(analog_in) && smp_v_r))
    else $error("input not sampled on this edge");

  a_conv_one_clock: assert property (
    @(posedge clk) disable iff (!arst_n)
    smp_v_r |=> (cv.done &&
      cv.code == sadc_pkg::sadc_quantize($past(sample_r), $past(gain_r))))
    else $error("conversion not done one clock after sampling");

  a_no_abort: assert property (
    @(posedge clk) disable iff (!arst_n)
    smp_v_r |-> ##`SADC_PIPE_CYC result_valid_r)
    else $error("started conversion never reached the output");

  a_word_latency: assert property (
    @(posedge clk) disable iff (!arst_n)
    result_valid_r |-> result_r == sadc_pkg::sadc_quantize(
      $past(analog_in, `SADC_LAT_EDGES),
      sadc_pkg::sadc_gain_e'($past(gain_sel, `SADC_LAT_EDGES))))
    else $error("word not from sample three edges back");

  a_sign_kept: assert property (
    @(posedge clk) disable iff (!arst_n)
    result_valid_r |-> result_r[`SADC_RES_W-1] ==
                       $past(analog_in[`SADC_AIN_W-1], `SADC_LAT_EDGES))
    else $error("result sign differs from input sign");

  a_unity_span: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && $past(gain_sel, `SADC_LAT_EDGES)) |->
      result_r == $past(analog_in[`SADC_AIN_W-1:`SADC_SHIFT_UNITY],
                        `SADC_LAT_EDGES))
    else $error("unity gain word not the top input bits");

  a_zero_cross: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && $past(gain_sel, `SADC_LAT_EDGES) &&
     $past(analog_in, `SADC_LAT_EDGES) == `SADC_AIN_NEG1) |->
      result_r == `SADC_CODE_NEG1)
    else $error("input just below zero not coded as fff");

  a_zero_below_dbl: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && !$past(gain_sel, `SADC_LAT_EDGES) &&
     $past(analog_in, `SADC_LAT_EDGES) == `SADC_AIN_NEG1) |->
      result_r == `SADC_CODE_NEG1)
    else $error("double gain input below zero not coded as fff");

  a_zero_above: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r &&
     $past(analog_in, `SADC_LAT_EDGES) == `SADC_AIN_ZERO) |->
      (result_r == `SADC_CODE_ZERO && !overflow_flag_r))
    else $error("zero input not coded as 000");

  a_flag_range: assert property (
    @(posedge clk) disable iff (!arst_n)
    result_valid_r |-> overflow_flag_r ==
      ((result_r == `SADC_CODE_MIN) || (result_r == `SADC_CODE_MAX)))
    else $error("overflow flag wrong for code");

  a_sat_high: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && $past(analog_in, `SADC_LAT_EDGES) == `SADC_AIN_POS_FS)
      |-> (result_r == `SADC_CODE_MAX && overflow_flag_r))
    else $error("top of input not coded 7ff with flag");

  a_sat_low: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && $past(analog_in, `SADC_LAT_EDGES) == `SADC_AIN_NEG_FS)
      |-> (result_r == `SADC_CODE_MIN && overflow_flag_r))
    else $error("bottom of input not coded 800 with flag");

  a_flag_with_word: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && $changed(overflow_flag_r)) |->
      $changed(result_r) && $past(cv.ovf) == overflow_flag_r)
    else $error("flag moved without its word");

  a_stage_flag: assert property (
    @(posedge clk) disable iff (!arst_n)
    cv.done |-> cv.ovf == sadc_pkg::sadc_is_range_end(cv.code))
    else $error("stage flag does not match its code");

  a_double_gain: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && !$past(gain_sel, `SADC_LAT_EDGES) &&
     $past(analog_in, `SADC_LAT_EDGES) <= `SADC_DBL_LIM &&
     $past(analog_in, `SADC_LAT_EDGES) >= `SADC_DBL_LIM_N) |->
      result_r == $past(
        analog_in[`SADC_RES_W+`SADC_SHIFT_DOUBLE-1:`SADC_SHIFT_DOUBLE],
        `SADC_LAT_EDGES))
    else $error("double gain span not halved");

  a_double_sat_hi: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && !$past(gain_sel, `SADC_LAT_EDGES) &&
     $past(analog_in, `SADC_LAT_EDGES) > `SADC_DBL_LIM) |->
      (result_r == `SADC_CODE_MAX && overflow_flag_r))
    else $error("double gain overrange not coded 7ff");

  a_double_sat_lo: assert property (
    @(posedge clk) disable iff (!arst_n)
    (result_valid_r && !$past(gain_sel, `SADC_LAT_EDGES) &&
     $past(analog_in, `SADC_LAT_EDGES) < `SADC_DBL_LIM_N) |->
      (result_r == `SADC_CODE_MIN && overflow_flag_r))
    else $error("double gain underrange not coded 800");

  a_take_no_gap: assert property (
    @(posedge clk) disable iff (!arst_n)
    smp_v_r |=> smp_v_r)
    else $error("sampling skipped an edge");

  a_valid_holds: assert property (
    @(posedge clk) disable iff (!arst_n)
    result_valid_r |=> result_valid_r)
    else $error("result stream stopped without reset");

  // helper for the checks only: counts edges since reset up to the first
  // word, so the fill delay is checked apart from the valid chain
  logic [1:0] fill_cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_cnt_r <= 2'h0;
    end else if (fill_cnt_r != `SADC_FILL_CNT) begin
      fill_cnt_r <= fill_cnt_r + 2'h1;
    end
  end

  a_fill_count: assert property (
    @(posedge clk) disable iff (!arst_n)
    result_valid_r == (fill_cnt_r == `SADC_FILL_CNT))
    else $error("valid not raised on the third edge after reset");

  a_valid_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(result_valid_r) |->
      ($past(smp_v_r, `SADC_PIPE_CYC) && !$past(smp_v_r, `SADC_LAT_EDGES)))
    else $error("valid rose at the wrong edge");

endmodule

// ---- tb/sadc_rx_model.sv ----
/*
  Receiving logic: latches each result word and flag on the edge after
  it is presented, and offers the straight binary form of the word.
  Assumes the converter runs on the same clk.
*/
`timescale 1ns/1ps

module sadc_rx_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // converter outputs
  input wire sadc_pkg::sadc_code_t result,
  input wire logic overflow_flag,
  input wire logic result_valid,
  // captured values
  output sadc_pkg::sadc_code_t cap_word,
  output sadc_pkg::sadc_code_t cap_straight,
  output logic cap_ovf,
  output logic cap_new
);
  // third edge after sampling; earlier edges would see the old word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_word <= 12'h000;
      cap_straight <= 12'h800;
      cap_ovf <= 1'b0;
      cap_new <= 1'b0;
    end else begin
      cap_word <= result;
      cap_straight <= {~result[11], result[10:0]};
      cap_ovf <= overflow_flag;
      cap_new <= result_valid;
    end
  end
endmodule

// ---- tb/test_sampling_adc_output_timing.sv ----
/*
  Self-checking bench: drives one sample per clock, notes the expected
  word in a queue and compares against what the receiver latched.
  Assumes the converter answers exactly two clocks after sampling.
*/
`timescale 1ns/1ps

module test_sampling_adc_output_timing;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] analog_in = 16'h0000;
  logic gain_sel = 1'b1;
  sadc_pkg::sadc_code_t result, cap_word, cap_straight, e;
  logic overflow_flag, result_valid, cap_ovf, cap_new;
  sadc_pkg::sadc_code_t expq[$];
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int since_rel = 0;
  logic [15:0] edges[8] = '{16'h0000, 16'hffff, 16'h7fff, 16'h8000,
                            16'h7fef, 16'h0010, 16'h3fff, 16'hc000};

  sadc_top i_sadc_top (.clk(clk), .arst_n(arst_n),
    .analog_in(analog_in), .gain_sel(gain_sel), .result(result),
    .overflow_flag(overflow_flag), .result_valid(result_valid));
  sadc_rx_model i_sadc_rx_model (.clk(clk), .arst_n(arst_n),
    .result(result), .overflow_flag(overflow_flag),
    .result_valid(result_valid), .cap_word(cap_word),
    .cap_straight(cap_straight), .cap_ovf(cap_ovf), .cap_new(cap_new));

  always #50 clk = ~clk;

  // own quantiser, kept apart from the design's function
  function automatic sadc_pkg::sadc_code_t exp_code(input logic [15:0] a,
                                                    input logic g);
    int s;
    s = int'($signed(a));
    s = g ? (s >>> 4) : (s >>> 3);
    if (s > 2047) s = 2047;
    if (s < -2048) s = -2048;
    return s[11:0];
  endfunction

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] expd);
    checked++;
    if (seen !== expd) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, expd, seen);
    end
  endtask

  task automatic drive(input logic [15:0] a, input logic g);
    analog_in = a;
    gain_sel = g;
    expq.push_back(exp_code(a, g));
  endtask

  task automatic end_of_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (arst_n) begin
      check("valid", {11'h0, result_valid}, {11'h0, since_rel >= 3});
    end
    if (arst_n && cap_new) begin
      if (expq.size() == 0) begin
        check("queue", 12'h001, 12'h000);
      end else begin
        e = expq.pop_front();
        check("word", cap_word, e);
        check("straight", cap_straight, e ^ 12'h800);
        check("ovf", {11'h0, cap_ovf},
              {11'h0, (e == 12'h800) || (e == 12'h7ff)});
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    since_rel = arst_n ? since_rel + 1 : 0;
    if (cycles > 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'h5c84dddd));
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    drive(analog_in, gain_sel);
    for (int g = 0; g < 2; g++) begin
      foreach (edges[i]) begin
        @(posedge clk) #1 drive(edges[i], g[0]);
      end
    end
    repeat (200) begin
      @(posedge clk) #1 drive(16'($urandom), 1'($urandom));
    end
    @(posedge clk) #1 arst_n = 1'b0;
    expq.delete();
    @(posedge clk) #1;
    check("rst_word", result, 12'h000);
    check("rst_flags", {10'h0, overflow_flag, result_valid}, 12'h000);
    arst_n = 1'b1;
    drive(analog_in, gain_sel);
    repeat (50) begin
      @(posedge clk) #1 drive(16'($urandom), 1'($urandom));
    end
    repeat (5) @(posedge clk);
    #1 check("pending", 12'(expq.size()), 12'h000);
    end_of_test();
  end
endmodule
